//--- pkg/afe_timing_map.svh
// register map, field positions, reset values and counts of the pulse timing block
`ifndef AFE_TIMING_MAP_SVH
`define AFE_TIMING_MAP_SVH

// register offsets
`define MAP_ADDR_MAIN_CFG    8'h00
`define MAP_ADDR_SH_CTRL     8'h06
`define MAP_ADDR_MON_SEL     8'h09
`define MAP_ADDR_CLAMP_START 8'h20
`define MAP_ADDR_CLAMP_END   8'h21
`define MAP_ADDR_SAMP_START  8'h22
`define MAP_ADDR_SAMP_END    8'h23
`define MAP_ADDR_STATUS      8'h24

// field positions
`define MAP_CDS_EN_BIT       0
`define MAP_SH_EN_BIT        7
`define MAP_MON_LO           3
`define MAP_MON_HI           4
`define MAP_MON_PULSES       2'h2
`define MAP_STAT_PARITY_BIT  0
`define MAP_STAT_CDS_BIT     1
`define MAP_STAT_FLAG_BIT    2

// reset values: baseline leaves sample & hold selected
`define MAP_RST_MAIN_CFG     8'h00
`define MAP_RST_SH_CTRL      8'h80
`define MAP_RST_MON_SEL      8'h00
`define MAP_RST_CLAMP_START  6'h04
`define MAP_RST_CLAMP_END    6'h0c
`define MAP_RST_SAMP_START   6'h20
`define MAP_RST_SAMP_END     6'h30

// timing counts
`define MAP_EDGE_FIRST       6'h00
`define MAP_EDGE_LAST        6'h3f
`define MAP_FLAG_PERIODS     2'h3

`endif

//--- pkg/afe_timing_pkg.sv
// types shared by the pulse timing block and its edge counter
package afe_timing_pkg;

   typedef enum logic {MODE_SH, MODE_CDS} mode_t;

   typedef struct packed {
      logic [5:0] edge_idx;
      logic       clk_prev;
   } cnt_state_t;

   typedef struct packed {
      logic [7:0] main_cfg;
      logic [7:0] sh_ctrl;
      logic [7:0] mon_sel;
      logic [5:0] c_start;
      logic [5:0] c_end;
      logic [5:0] s_start;
      logic [5:0] s_end;
      logic [5:0] c_start_sh;
      logic [5:0] c_end_sh;
      logic [5:0] s_start_sh;
      logic [5:0] s_end_sh;
      mode_t      mode_sh;
      logic       parity;
      logic       clamp_q;
      logic       sample_q;
      logic       clamp_even;
      logic       clamp_odd;
      logic       sample_even;
      logic       sample_odd;
      logic       mon0;
      logic       mon1;
      logic       gated;
      logic       flag;
      logic [1:0] flag_cnt;
      logic       bclk_prev;
      logic [7:0] rdata;
      logic       rvalid;
   } timing_state_t;

endpackage

//--- rtl/edge_phase_counter.sv
// splits each input clock period into 64 numbered edges
`include "afe_timing_map.svh"

module edge_phase_counter (
   // clock and reset
   input  wire logic       i_core_clk,
   input  wire logic       i_rst,
   // input clock, sampled as a level
   input  wire logic       i_input_clock,
   // edge index and wrap indication
   output logic      [5:0] o_edge,
   output logic            o_wrap_next
);

   afe_timing_pkg::cnt_state_t st_reg;
   afe_timing_pkg::cnt_state_t st_next;

   // a rising input clock realigns edge zero, else the count wraps at 63
   always_comb begin
      logic rise;
      rise    = i_input_clock & ~st_reg.clk_prev;
      st_next = st_reg;
      st_next.clk_prev = i_input_clock;
      if (rise || st_reg.edge_idx == `MAP_EDGE_LAST) begin // R1
         st_next.edge_idx = `MAP_EDGE_FIRST;
      end else begin
         st_next.edge_idx = 6'(st_reg.edge_idx + 6'h01);
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         st_reg <= '0;
         st_reg.clk_prev <= 1'b1; // a pin already high at release is no rise
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_edge      = st_reg.edge_idx;
   assign o_wrap_next = (st_next.edge_idx == `MAP_EDGE_FIRST);

   a_edge_step : assert property (@(posedge i_core_clk) disable iff (i_rst) // R1
      (!o_wrap_next) |=> (o_edge == 6'($past(o_edge) + 6'h01)))
      else $error("edge index did not advance by one");

   a_edge_wrap : assert property (@(posedge i_core_clk) disable iff (i_rst) // R1
      (o_edge == `MAP_EDGE_LAST) |=> (o_edge == `MAP_EDGE_FIRST))
      else $error("edge index did not wrap after 63");

endmodule

//--- rtl/pixel_sampling_timing.sv
// clamp and sample pulse timing generator with even/odd paths and monitor routing
//
// Behaviour
// R1 - each input clock period is split into 64 numbered edges, from zero.
// R2 - sample pulse runs from the sample start edge to the sample end edge.
// R3 - in sample and hold, clamp positions never affect the sample pulse.
// R4 - start above end makes the sample pulse wrap into the next period.
// R5 - monitor select 10 routes clamp and sample pulses, sample on monitor pin 1.
// R6 - in double sampling, monitor pins show odd clamp and odd sample only.
// R7 - in double sampling, the four positions place even and odd sets alike.
// R8 - sample positions below clamp positions put sample one period after clamp.
// R9 - reset configuration leaves the block in sample and hold mode.
// R10 - software clears the sample-hold enable before selecting double sampling.
// R11 - software then sets the double sampling enable and positions the pulses.
// R12 - double sampling alternates even and odd paths on successive pixels.
// R13 - double sampling raises the frame flag three bit clocks on odd pixels.
// R14 - sample and hold raises the frame flag three bit clocks every pixel.
// R15 - double sampling: clamp takes the reference, sample takes the video level.
// R16 - software should make the sample pulse as wide as the video level.
// R17 - the internal clamp pulse can gate the external clamp input.
// R18 - gated clamp control is internal clamp AND external clamp input.
// R19 - positions are six-bit edge indices; equal start and end is one edge.
// R20 - position changes take effect at the start of the next input period.
`include "afe_timing_map.svh"

module pixel_sampling_timing (
   // clock and reset
   input  wire logic       I_CORE_CLK,
   input  wire logic       I_RST,
   // sensor side timing inputs, synchronous levels
   input  wire logic       I_INPUT_CLOCK,
   input  wire logic       I_OUTPUT_BIT_CLOCK,
   input  wire logic       I_EXTERNAL_CLAMP_INPUT,
   // register port
   input  wire logic       I_REG_WR,
   input  wire logic       I_REG_RD,
   input  wire logic [7:0] I_REG_ADDR,
   input  wire logic [7:0] I_REG_WDATA,
   output logic      [7:0] O_REG_RDATA,
   output logic            O_REG_RVALID,
   // sampling path pulses
   output logic            O_CLAMP_EVEN,
   output logic            O_CLAMP_ODD,
   output logic            O_SAMPLE_EVEN,
   output logic            O_SAMPLE_ODD,
   // monitor, clamp gate and frame flag
   output logic            O_TEST_MONITOR_PIN_0,
   output logic            O_TEST_MONITOR_PIN_1,
   output logic            O_GATED_CLAMP_CONTROL,
   output logic            O_PIXEL_PARITY_FRAME_FLAG
);

   afe_timing_pkg::timing_state_t st_reg;
   afe_timing_pkg::timing_state_t st_next;

   logic [5:0] edge_idx;
   logic       wrap_next;

   // edge numbering within the input clock period
   edge_phase_counter u_edges (
      .i_core_clk    (I_CORE_CLK),
      .i_rst         (I_RST),
      .i_input_clock (I_INPUT_CLOCK),
      .o_edge        (edge_idx),
      .o_wrap_next   (wrap_next)
   );

   // true while e lies in the window from s to f, wrapping past edge 63
   function automatic logic in_window(input logic [5:0] e,
                                      input logic [5:0] s,
                                      input logic [5:0] f);
      logic hit;
      if (s <= f) begin
         hit = (e >= s) && (e <= f); // R19
      end else begin
         hit = (e >= s) || (e <= f); // R4
      end
      return hit;
   endfunction

   // all state steps here; outputs are the registered copy
   always_comb begin
      logic                  clamp_raw;
      logic                  samp_raw;
      logic                  samp_late;
      logic                  samp_par;
      logic                  bclk_rise;
      logic                  cds_live;
      logic                  par_new;
      afe_timing_pkg::mode_t mode_new;

      st_next   = st_reg;
      clamp_raw = 1'b0;
      samp_raw  = 1'b0;
      samp_late = 1'b0;
      samp_par  = 1'b0;
      bclk_rise = I_OUTPUT_BIT_CLOCK & ~st_reg.bclk_prev;
      cds_live  = st_reg.main_cfg[`MAP_CDS_EN_BIT] & ~st_reg.sh_ctrl[`MAP_SH_EN_BIT];
      mode_new  = cds_live ? afe_timing_pkg::MODE_CDS : afe_timing_pkg::MODE_SH;
      par_new   = 1'b0;

      // register writes; positions keep only the six-bit edge index
      if (I_REG_WR) begin
         unique case (I_REG_ADDR)
            `MAP_ADDR_MAIN_CFG:    st_next.main_cfg = I_REG_WDATA;
            `MAP_ADDR_SH_CTRL:     st_next.sh_ctrl  = I_REG_WDATA;
            `MAP_ADDR_MON_SEL:     st_next.mon_sel  = I_REG_WDATA;
            `MAP_ADDR_CLAMP_START: st_next.c_start  = I_REG_WDATA[5:0]; // R19
            `MAP_ADDR_CLAMP_END:   st_next.c_end    = I_REG_WDATA[5:0]; // R19
            `MAP_ADDR_SAMP_START:  st_next.s_start  = I_REG_WDATA[5:0]; // R19
            `MAP_ADDR_SAMP_END:    st_next.s_end    = I_REG_WDATA[5:0]; // R19
            default: ;
         endcase
      end

      // register reads answer one cycle later; unmapped reads give zero
      st_next.rvalid = I_REG_RD;
      st_next.rdata  = 8'h00;
      if (I_REG_RD) begin
         unique case (I_REG_ADDR)
            `MAP_ADDR_MAIN_CFG:    st_next.rdata = st_reg.main_cfg;
            `MAP_ADDR_SH_CTRL:     st_next.rdata = st_reg.sh_ctrl;
            `MAP_ADDR_MON_SEL:     st_next.rdata = st_reg.mon_sel;
            `MAP_ADDR_CLAMP_START: st_next.rdata = {2'h0, st_reg.c_start};
            `MAP_ADDR_CLAMP_END:   st_next.rdata = {2'h0, st_reg.c_end};
            `MAP_ADDR_SAMP_START:  st_next.rdata = {2'h0, st_reg.s_start};
            `MAP_ADDR_SAMP_END:    st_next.rdata = {2'h0, st_reg.s_end};
            `MAP_ADDR_STATUS: begin
               st_next.rdata[`MAP_STAT_PARITY_BIT] = st_reg.parity;
               st_next.rdata[`MAP_STAT_CDS_BIT] =
                  (st_reg.mode_sh == afe_timing_pkg::MODE_CDS);
               st_next.rdata[`MAP_STAT_FLAG_BIT] = st_reg.flag;
            end
            default: ;
         endcase
      end

      // positions and mode are taken only at a period boundary, so a write
      // mid-period never cuts or doubles a pulse that does not wrap past edge 63
      if (wrap_next) begin
         st_next.c_start_sh = st_reg.c_start; // R20
         st_next.c_end_sh   = st_reg.c_end;   // R20
         st_next.s_start_sh = st_reg.s_start; // R20
         st_next.s_end_sh   = st_reg.s_end;   // R20
         st_next.mode_sh    = mode_new;       // R9
         // one path in sample and hold; alternate paths in double sampling
         par_new = (mode_new == afe_timing_pkg::MODE_CDS) ? ~st_reg.parity : 1'b0; // R12
         st_next.parity = par_new;
      end

      // raw pulses from the edge index and the held positions
      clamp_raw = in_window(edge_idx, st_reg.c_start_sh, st_reg.c_end_sh);
      samp_raw  = in_window(edge_idx, st_reg.s_start_sh, st_reg.s_end_sh); // R2
      st_next.clamp_q  = clamp_raw;
      st_next.sample_q = samp_raw;

      // a sample placed below the clamp belongs to the previous period's pixel
      samp_late = (st_reg.s_start_sh < st_reg.c_start_sh); // R8
      samp_par  = samp_late ? ~st_reg.parity : st_reg.parity; // R8

      // path pulses: clamp holds the reference, sample holds the video level
      unique case (st_reg.mode_sh)
         afe_timing_pkg::MODE_CDS: begin
            st_next.clamp_even  = clamp_raw & ~st_reg.parity; // R15 R7
            st_next.clamp_odd   = clamp_raw &  st_reg.parity; // R15 R7
            st_next.sample_even = samp_raw  & ~samp_par;      // R15 R7
            st_next.sample_odd  = samp_raw  &  samp_par;      // R15 R7
         end
         afe_timing_pkg::MODE_SH: begin
            // clamp positions do not reach the single sampling path
            st_next.clamp_even  = 1'b0;     // R3
            st_next.clamp_odd   = 1'b0;     // R3
            st_next.sample_even = samp_raw; // R3
            st_next.sample_odd  = 1'b0;
         end
      endcase

      // monitor routing; other select codes leave the pins low
      st_next.mon0 = 1'b0;
      st_next.mon1 = 1'b0;
      if (st_reg.mon_sel[`MAP_MON_HI:`MAP_MON_LO] == `MAP_MON_PULSES) begin
         if (st_reg.mode_sh == afe_timing_pkg::MODE_CDS) begin
            st_next.mon0 = clamp_raw & st_reg.parity; // R6
            st_next.mon1 = samp_raw & samp_par;       // R6
         end else begin
            st_next.mon0 = clamp_raw; // R5
            st_next.mon1 = samp_raw;  // R5
         end
      end

      // clamp switch acts only inside the internal clamp window
      st_next.gated = clamp_raw & I_EXTERNAL_CLAMP_INPUT; // R17 R18

      // frame flag: starts at each pixel boundary in sample and hold and at each odd pixel boundary
      // in double sampling, drops after three bit clock rises; a missing bit clock leaves it high, in double sampling only until the next pixel boundary
      st_next.bclk_prev = I_OUTPUT_BIT_CLOCK;
      if (st_reg.flag && bclk_rise) begin
         if (st_reg.flag_cnt == 2'(`MAP_FLAG_PERIODS - 2'h1)) begin
            st_next.flag = 1'b0; // R13 R14
         end else begin
            st_next.flag_cnt = 2'(st_reg.flag_cnt + 2'h1);
         end
      end
      if (wrap_next) begin
         if (mode_new == afe_timing_pkg::MODE_SH || par_new) begin
            st_next.flag     = 1'b1; // R13 R14
            st_next.flag_cnt = 2'h0;
         end else begin
            st_next.flag     = 1'b0; // R13
            st_next.flag_cnt = 2'h0;
         end
      end
   end

   // state register with the baseline configuration at reset
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         st_reg          <= '0;
         st_reg.main_cfg <= `MAP_RST_MAIN_CFG; // R9
         st_reg.sh_ctrl  <= `MAP_RST_SH_CTRL;  // R9
         st_reg.mon_sel  <= `MAP_RST_MON_SEL;
         st_reg.c_start  <= `MAP_RST_CLAMP_START;
         st_reg.c_end    <= `MAP_RST_CLAMP_END;
         st_reg.s_start  <= `MAP_RST_SAMP_START;
         st_reg.s_end    <= `MAP_RST_SAMP_END;
         st_reg.c_start_sh <= `MAP_RST_CLAMP_START;
         st_reg.c_end_sh   <= `MAP_RST_CLAMP_END;
         st_reg.s_start_sh <= `MAP_RST_SAMP_START;
         st_reg.s_end_sh   <= `MAP_RST_SAMP_END;
         st_reg.mode_sh    <= afe_timing_pkg::MODE_SH; // R9
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs straight from the state register
   assign O_REG_RDATA               = st_reg.rdata;
   assign O_REG_RVALID              = st_reg.rvalid;
   assign O_CLAMP_EVEN              = st_reg.clamp_even;
   assign O_CLAMP_ODD               = st_reg.clamp_odd;
   assign O_SAMPLE_EVEN             = st_reg.sample_even;
   assign O_SAMPLE_ODD              = st_reg.sample_odd;
   assign O_TEST_MONITOR_PIN_0      = st_reg.mon0;
   assign O_TEST_MONITOR_PIN_1      = st_reg.mon1;
   assign O_GATED_CLAMP_CONTROL     = st_reg.gated;
   assign O_PIXEL_PARITY_FRAME_FLAG = st_reg.flag;

   // checks
   sequence seq_pixel_start;
      wrap_next;
   endsequence

   sequence seq_flag_started;
      ##1 O_PIXEL_PARITY_FRAME_FLAG && (st_reg.flag_cnt == 2'h0);
   endsequence

   a_sh_no_clamp : assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // R3
      (st_reg.mode_sh == afe_timing_pkg::MODE_SH)
         |=> (!O_CLAMP_EVEN && !O_CLAMP_ODD && !O_SAMPLE_ODD))
      else $error("clamp path active in sample and hold mode");

   a_sample_start : assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // R2
      (edge_idx == st_reg.s_start_sh) |=> st_reg.sample_q)
      else $error("sample pulse missing at start edge");

   a_sample_after_end : assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // R2
      (st_reg.s_start_sh <= st_reg.s_end_sh && edge_idx > st_reg.s_end_sh)
         |=> !st_reg.sample_q)
      else $error("sample pulse runs past end edge");

   a_sample_wraps : assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // R4
      (edge_idx == `MAP_EDGE_FIRST && st_reg.s_start_sh > st_reg.s_end_sh)
         |=> st_reg.sample_q)
      else $error("wrapped sample pulse missing at edge zero");

   a_mon_route_sh : assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // R5
      (st_reg.mon_sel[`MAP_MON_HI:`MAP_MON_LO] == `MAP_MON_PULSES
         && st_reg.mode_sh == afe_timing_pkg::MODE_SH && edge_idx == st_reg.s_start_sh)
         |=> O_TEST_MONITOR_PIN_1)
      else $error("sample pulse not routed to monitor pin 1");

   a_mon_odd_only : assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // R6
      (st_reg.mode_sh == afe_timing_pkg::MODE_CDS && !st_reg.parity)
         |=> !O_TEST_MONITOR_PIN_0)
      else $error("monitor pin 0 pulsed on an even pixel");

   a_gated_and : assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // R18
      O_GATED_CLAMP_CONTROL |-> ($past(I_EXTERNAL_CLAMP_INPUT) && st_reg.clamp_q))
      else $error("gated clamp without both inputs");

   a_parity_alt : assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // R12
      (seq_pixel_start ##0 (st_reg.mode_sh == afe_timing_pkg::MODE_CDS
         && st_reg.main_cfg[`MAP_CDS_EN_BIT] && !st_reg.sh_ctrl[`MAP_SH_EN_BIT]))
         |=> (st_reg.parity != $past(st_reg.parity)))
      else $error("path parity did not alternate");

   a_flag_sh_start : assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // R14
      (seq_pixel_start ##0 !st_reg.main_cfg[`MAP_CDS_EN_BIT]) |-> seq_flag_started)
      else $error("frame flag not raised for a pixel in sample and hold");

   a_flag_bound : assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // R13
      (O_PIXEL_PARITY_FRAME_FLAG && st_reg.flag_cnt == 2'(`MAP_FLAG_PERIODS - 2'h1)
         && I_OUTPUT_BIT_CLOCK && !st_reg.bclk_prev && !wrap_next)
         |=> !O_PIXEL_PARITY_FRAME_FLAG)
      else $error("frame flag held past three bit clocks");

   a_shadow_hold : assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // R20
      (!wrap_next) |=> ($stable(st_reg.s_start_sh) && $stable(st_reg.s_end_sh)
         && $stable(st_reg.c_start_sh) && $stable(st_reg.c_end_sh)))
      else $error("pulse position changed inside a period");

   a_gate_pass : assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // R17
      (I_EXTERNAL_CLAMP_INPUT && in_window(edge_idx, st_reg.c_start_sh, st_reg.c_end_sh))
         |=> O_GATED_CLAMP_CONTROL)
      else $error("gated clamp missing in window");

   a_clamp_odd_set : assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // R7
      (st_reg.mode_sh == afe_timing_pkg::MODE_CDS && st_reg.parity
         && edge_idx == st_reg.c_start_sh) |=> O_CLAMP_ODD)
      else $error("odd clamp missing at start edge");

   a_clamp_even_set : assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // R7
      (st_reg.mode_sh == afe_timing_pkg::MODE_CDS && !st_reg.parity
         && edge_idx == st_reg.c_start_sh) |=> O_CLAMP_EVEN)
      else $error("even clamp missing at start edge");

   a_sample_late : assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // R8
      (st_reg.mode_sh == afe_timing_pkg::MODE_CDS && !st_reg.parity
         && st_reg.s_start_sh < st_reg.c_start_sh && edge_idx == st_reg.s_start_sh)
         |=> O_SAMPLE_ODD)
      else $error("late sample not on the odd path");

   a_mon_idle : assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // R5
      (st_reg.mon_sel[`MAP_MON_HI:`MAP_MON_LO] != `MAP_MON_PULSES)
         |=> (!O_TEST_MONITOR_PIN_0 && !O_TEST_MONITOR_PIN_1))
      else $error("monitor pins active while deselected");

   a_flag_even_off : assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // R13
      (seq_pixel_start ##0 (st_reg.main_cfg[`MAP_CDS_EN_BIT]
         && !st_reg.sh_ctrl[`MAP_SH_EN_BIT] && st_reg.parity))
         |=> !O_PIXEL_PARITY_FRAME_FLAG)
      else $error("frame flag raised for an even pixel");

endmodule

//--- dv/sensor_timing_model.sv
// sensor side model: input clock of 64 core cycles and a free running bit clock
module sensor_timing_model (
   // core clock
   input  wire logic i_core_clk,
   // timing levels toward the block
   output logic      o_input_clock,
   output logic      o_bit_clock
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [5:0] phase_reg = 6'h00;

   // levels move on the falling edge, clear of the block's sampling edge
   always @(negedge i_core_clk) begin
      phase_reg <= phase_reg + 6'h01;
   end

   // one input period is exactly 64 core cycles, half high
   assign o_input_clock = phase_reg[5];
   // bit clock period of 4 cycles, so three rises fit well inside a pixel
   assign o_bit_clock = phase_reg[1];
endmodule

//--- dv/tb_pixel_sampling_timing.sv
// self-checking bench for the clamp and sample pulse timing generator
module tb_pixel_sampling_timing;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int FLAG = 0, GATE = 1, MON1 = 2, MON0 = 3;
   localparam int S_ODD = 4, S_EVEN = 5, C_ODD = 6, C_EVEN = 7;

   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic       ext_clamp = 1'b0;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic       in_clk, bit_clk, rvalid;
   logic [7:0] rdata, obs, v;
   logic       c_even, c_odd, s_even, s_odd, mon0, mon1, gated, flag;
   logic [7:0] exp_q[$];
   logic [7:0] ra[7] = '{8'h00, 8'h06, 8'h09, 8'h20, 8'h21, 8'h22, 8'h23};
   logic [7:0] rv[7] = '{8'h00, 8'h80, 8'h00, 8'h04, 8'h0c, 8'h20, 8'h30};
   int         n_errors = 0;
   int         n_tests = 0;
   int         cycles = 0;
   int         w, d, c, k, bc_cnt, bc_last;
   logic       prev_flag = 1'b0;
   logic       prev_bclk = 1'b0;

   always #5 clk = ~clk;
   assign obs = {c_even, c_odd, s_even, s_odd, mon0, mon1, gated, flag};

   sensor_timing_model u_sensor_timing_model (
      .i_core_clk    (clk),
      .o_input_clock (in_clk),
      .o_bit_clock   (bit_clk)
   );

   pixel_sampling_timing u_pixel_sampling_timing (
      .I_CORE_CLK                (clk),
      .I_RST                     (rst),
      .I_INPUT_CLOCK             (in_clk),
      .I_OUTPUT_BIT_CLOCK        (bit_clk),
      .I_EXTERNAL_CLAMP_INPUT    (ext_clamp),
      .I_REG_WR                  (wr),
      .I_REG_RD                  (rd),
      .I_REG_ADDR                (addr),
      .I_REG_WDATA               (wdata),
      .O_REG_RDATA               (rdata),
      .O_REG_RVALID              (rvalid),
      .O_CLAMP_EVEN              (c_even),
      .O_CLAMP_ODD               (c_odd),
      .O_SAMPLE_EVEN             (s_even),
      .O_SAMPLE_ODD              (s_odd),
      .O_TEST_MONITOR_PIN_0      (mon0),
      .O_TEST_MONITOR_PIN_1      (mon1),
      .O_GATED_CLAMP_CONTROL     (gated),
      .O_PIXEL_PARITY_FRAME_FLAG (flag)
   );

   task automatic final_report;
      if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input string name, input int exp, input int got);
      n_tests++;
      if (got != exp) begin
         n_errors++;
         $display("BAD %s expected %0d seen %0d", name, exp, got);
      end
   endtask

   task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask

   // strobes are lowered a full cycle before the next request
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] val);
      @(negedge clk);
      wr = 1'b1;
      addr = a;
      wdata = val;
      @(negedge clk);
      wr = 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] a, input logic [7:0] val);
      @(negedge clk);
      rd = 1'b1;
      addr = a;
      exp_q.push_back(val);
      @(negedge clk);
      rd = 1'b0;
   endtask

   // positions only land at the next period start, so give two periods
   task automatic settle;
      repeat (130) @(negedge clk);
   endtask

   task automatic wait_rise(input int i);
      logic p;
      int   n;
      p = obs[i];
      for (n = 0; n < 400; n++) begin
         @(negedge clk);
         if (obs[i] === 1'b1 && p !== 1'b1) return;
         p = obs[i];
      end
      chk("rise seen on output", 1, 0);
   endtask

   task automatic width(input int i, output int wd);
      int n;
      wait_rise(i);
      wd = 1;
      for (n = 0; n < 100; n++) begin
         @(negedge clk);
         if (obs[i] !== 1'b1) break;
         wd++;
      end
   endtask

   task automatic gap(input int a, input int b, output int dd);
      logic p;
      wait_rise(a);
      p = obs[b];
      for (dd = 1; dd < 400; dd++) begin
         @(negedge clk);
         if (obs[b] === 1'b1 && p !== 1'b1) return;
         p = obs[b];
      end
   endtask

   task automatic rises(input int i, input int n, output int cnt);
      logic p;
      cnt = 0;
      p = obs[i];
      repeat (n) begin
         @(negedge clk);
         if (obs[i] === 1'b1 && p !== 1'b1) cnt++;
         p = obs[i];
      end
   endtask

   // read answers and bit clock rises while the frame flag stands
   always @(negedge clk) begin
      if (!rst && rvalid === 1'b1) begin
         if (exp_q.size() == 0) chk("unrequested read", 0, 1);
         else chk8("read data", exp_q.pop_front(), rdata);
      end
      if (prev_flag !== 1'b1 && flag === 1'b1) bc_cnt = 0;
      if (prev_flag === 1'b1 && bit_clk && !prev_bclk) bc_cnt++;
      if (prev_flag === 1'b1 && flag !== 1'b1) bc_last = bc_cnt;
      prev_flag = flag;
      prev_bclk = bit_clk;
   end

   // hang guard, well above the expected run length
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         final_report();
      end
   end

   initial begin
      void'($urandom(32'h1827_8efb));
      repeat (20) @(negedge clk);
      rst = 1'b0;
      for (k = 0; k < 7; k++) reg_rd(ra[k], rv[k]);
      reg_wr(8'h55, 8'hff);
      reg_rd(8'h55, 8'h00);
      for (k = 3; k < 7; k++) begin
         v = 8'($urandom);
         reg_wr(ra[k], v);
         reg_rd(ra[k], {2'b00, v[5:0]});
      end
      for (k = 3; k < 7; k++) reg_wr(ra[k], rv[k]);
      settle();
      width(S_EVEN, w);
      chk("sh sample width", 17, w);
      gap(S_EVEN, S_EVEN, d);
      chk("sh period", 64, d);
      rises(S_ODD, 128, c);
      chk("sh odd path", 0, c);
      rises(FLAG, 128, c);
      chk("sh flag count", 2, c);
      chk("sh flag bit clocks", 3, bc_last);
      // wrapping window with clamp positions moved too
      reg_wr(8'h22, 8'h3c);
      reg_wr(8'h23, 8'h03);
      reg_wr(8'h20, 8'h3e);
      reg_wr(8'h21, 8'h01);
      settle();
      width(S_EVEN, w);
      chk("wrap width", 8, w);
      rises(C_EVEN, 128, c);
      chk("sh clamp off", 0, c);
      reg_wr(8'h09, 8'h10);
      reg_wr(8'h22, 8'h10);
      reg_wr(8'h23, 8'h10);
      settle();
      width(MON1, w);
      chk("single edge", 1, w);
      reg_wr(8'h23, 8'h30);
      settle();
      width(MON1, w);
      chk("monitor sample width", 33, w);
      reg_wr(8'h09, 8'h08);
      settle();
      rises(MON1, 128, c);
      chk("monitor off", 0, c);
      // double sampling entry sequence
      reg_wr(8'h06, 8'h00);
      reg_wr(8'h00, 8'h01);
      reg_wr(8'h09, 8'h10);
      for (k = 3; k < 7; k++) reg_wr(ra[k], rv[k]);
      settle();
      width(C_ODD, w);
      chk("odd clamp width", 9, w);
      width(C_EVEN, w);
      chk("even clamp width", 9, w);
      width(S_ODD, w);
      chk("odd sample width", 17, w);
      gap(S_EVEN, S_ODD, d);
      chk("even to odd", 64, d);
      rises(S_EVEN, 256, c);
      chk("even sample count", 2, c);
      width(MON0, w);
      chk("monitor odd clamp", 9, w);
      rises(MON1, 256, c);
      chk("monitor odd sample", 2, c);
      rises(FLAG, 256, c);
      chk("cds flag count", 2, c);
      chk("cds flag bit clocks", 3, bc_last);
      ext_clamp = 1'b1;
      width(GATE, w);
      chk("gated width", 9, w);
      ext_clamp = 1'b0;
      rises(GATE, 128, c);
      chk("gated blocked", 0, c);
      // sample placed below clamp lands one period later
      reg_wr(8'h20, 8'h14);
      reg_wr(8'h21, 8'h1e);
      reg_wr(8'h22, 8'h02);
      reg_wr(8'h23, 8'h0a);
      settle();
      gap(C_ODD, S_ODD, d);
      chk("late sample gap", 46, d);
      // end moved while a pulse is running: that pulse keeps its width
      wait_rise(S_EVEN);
      reg_wr(8'h23, 8'h04);
      w = 2;
      while (s_even === 1'b1 && w < 80) begin
         w++;
         @(negedge clk);
      end
      chk("held width", 9, w);
      settle();
      width(S_EVEN, w);
      chk("new width", 3, w);
      chk("reads left", 0, exp_q.size());
      final_report();
   end
endmodule
